// File: hdl/vmx_defs.svh
// Offsets, field masks, reset values and timing constants of the voice mixer and envelopes
`ifndef VMX_DEFS_SVH
`define VMX_DEFS_SVH
`define VMX_CLK_HZ 100000000
`define VMX_SAMPLE_HZ 48000
`define VMX_HOLD_MAX_MS 500
`define VMX_MS_PER_S 1000
`define VMX_HOLD_STEPS 127
`define VMX_ATK_SHIFT 24
`define VMX_DEC_SHIFT 24
`define VMX_REL_SHIFT 23
`define VMX_REP_CONT 7'h7F
`define VMX_VEL_CENTER 9'h040
`define VMX_GAIN_UNITY 9'h080
`define VMX_ACC_MAX 32'hFFFF_FFFF
`define VMX_IDX_MIX 4'h0
`define VMX_IDX_CTRL 4'h1
`define VMX_IDX_ROUTE 4'h2
`define VMX_IDX_STATUS 4'h3
`define VMX_IDX_ENV 4'h4
`define VMX_IDX_LVL 4'hA
`define VMX_IDX_LAST 4'hC
`define VMX_CTRL_MASK 32'h0013_FFFF
`define VMX_ADSR_MASK 32'h7F7F_7F7F
`define VMX_EXT_MASK 32'h017F_7F7F
`define VMX_MIX_RST 32'h0000_00FF
`define VMX_CTRL_RST 32'h0000_8000
`define VMX_ROUTE_RST 32'h0000_0000
`define VMX_ADSR_RST 32'h287F_4000
`define VMX_EXT_AMP_RST 32'h0000_0000
`define VMX_EXT_MOD_RST 32'h0100_0000
`define VMX_RESP_OKAY 2'b00
`define VMX_RESP_SLVERR 2'b10
`endif

// File: hdl/vmx_pkg.sv
// Types shared by the voice mixer and envelope block
package vmx_pkg;
  typedef enum logic [2:0] {ENV_IDLE = 3'b000, ENV_ATTACK = 3'b001, ENV_HOLD = 3'b010,
    ENV_DECAY = 3'b011, ENV_SUSTAIN = 3'b100, ENV_RELEASE = 3'b101} vmx_phase_t;
  typedef enum logic [1:0] {VM_POLY = 2'b00, VM_MONO = 2'b01, VM_MONO_LEGATO = 2'b10,
    VM_DUAL_MONO = 2'b11} vmx_voice_mode_t;
  typedef enum logic {TRIG_LEGATO = 1'b0, TRIG_RETRIGGER = 1'b1} vmx_trig_t;
  typedef struct packed {logic r3; logic [6:0] release_s; logic r2; logic [6:0] sustain;
    logic r1; logic [6:0] decay; logic r0; logic [6:0] attack;} vmx_adsr_t;
  typedef struct packed {logic [6:0] r3; vmx_trig_t trig; logic r2; logic signed [6:0] vel;
    logic r1; logic [6:0] repeats; logic r0; logic [6:0] hold_duration;} vmx_envx_t;
  typedef struct packed {logic [10:0] r1; logic amp_to_filter; logic [1:0] r0;
    vmx_voice_mode_t mode; logic [7:0] master_output_gain; logic [7:0] ring;} vmx_ctrl_t;
  typedef struct packed {logic [7:0] noise; logic [7:0] osc3; logic [7:0] osc2;
    logic [7:0] osc1;} vmx_mix_t;
  typedef struct packed {logic signed [7:0] amp_filt; logic signed [7:0] pitch;
    logic signed [7:0] filt; logic signed [7:0] shape;} vmx_route_t;
  typedef struct packed {logic signed [15:0] osc1; logic signed [15:0] osc2;
    logic signed [15:0] osc3; logic signed [15:0] noise; logic signed [15:0] ring;} vmx_src_t;
  typedef struct packed {logic strike; logic gate; logic overlap; logic [6:0] velocity;} vmx_key_t;
  typedef struct packed {logic signed [15:0] shape; logic signed [15:0] filter;
    logic signed [15:0] pitch;} vmx_mod_t;
endpackage

// File: hdl/vmx_voice.sv
// Voice mixer, three AHDSR envelopes and their AXI4-Lite register file
// Notes on behaviour
// R1 - Five scaled inputs summed, then master gain
// R2 - Each key press starts all three envelopes
// R3 - Attack ramps from zero to maximum
// R4 - Hold keeps maximum for hold time
// R5 - Decay falls from maximum to sustain
// R6 - Sustain level held while key down
// R7 - Key release falls to zero over release
// R8 - Attack zero instant; maximum above eighteen seconds
// R9 - Longest decay about twenty two seconds
// R10 - Sustain zero silences note after decay
// R11 - Release above twenty four seconds, nonlinear
// R12 - Amp envelope drives gain; filter optional
// R13 - Signed velocity sensitivity scales envelope depth
// R14 - Retrigger restarts attack on every note
// R15 - Legato overlapping notes jump to sustain
// R16 - Legato only in two mono modes
// R17 - Amp defaults legato, mod envelopes retrigger
// R18 - Mod envelopes feed shape, filter, pitch
// R19 - Note source flags overlapping key presses
// R20 - Hold 0 to 127, max 500 ms
// R21 - Repeats loop attack, hold, decay
// R22 - Seven-bit settings mapped to increments
// R23 - Early release falls from current level
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "vmx_defs.svh"
module vmx_voice #(
  parameter int CLK_HZ = `VMX_CLK_HZ,
  parameter int SAMPLE_HZ = `VMX_SAMPLE_HZ,
  parameter int AW = 8
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic [AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire vmx_pkg::vmx_key_t KEY,
  input wire vmx_pkg::vmx_src_t MIX_SRC,
  output logic signed [15:0] VOICE_OUT,
  output logic [15:0] ENV_LEVEL,
  output vmx_pkg::vmx_mod_t MOD_OUT
);
  import vmx_pkg::*;

  localparam int TICK_DIV = CLK_HZ / SAMPLE_HZ;
  localparam int HOLD_MAX_TICKS = `VMX_HOLD_MAX_MS * SAMPLE_HZ / `VMX_MS_PER_S;
  localparam int HOLD_STEP_I = (HOLD_MAX_TICKS + `VMX_HOLD_STEPS - 1) / `VMX_HOLD_STEPS;
  localparam logic [7:0] HOLD_STEP = 8'(HOLD_STEP_I);

  // Counters below are 16 and 8 bits wide; refuse rates they cannot hold
  if (TICK_DIV < 2 || TICK_DIV > 65535 || HOLD_STEP_I < 1 || HOLD_STEP_I > 255 || AW < 6) begin
    $error("vmx_voice: unsupported clock, sample rate or address width");
  end

  // Nonlinear curve: three mantissa bits, four exponent bits per setting
  function automatic logic [31:0] rate_inc(input logic [6:0] s, input int sh);
    logic [31:0] m;
    m = {28'h000_0000, 1'b1, ~s[2:0]};
    rate_inc = (m << sh) >> s[6:3];
  endfunction

  function automatic logic [31:0] sus_acc(input logic [6:0] s);
    sus_acc = {s, s, s[6:5], 16'h0000};
  endfunction

  function automatic logic [7:0] vel_gain(input logic signed [6:0] sens, input logic [6:0] vel);
    logic signed [8:0] vd;
    logic signed [15:0] p;
    vd = $signed({2'b00, vel}) - $signed(`VMX_VEL_CENTER);
    p = sens * vd;
    vel_gain = 8'($signed(`VMX_GAIN_UNITY) + 9'(p >>> 6));
  endfunction

  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sd32767) sat16 = 16'sh7FFF;
    else if (v < -32'sd32768) sat16 = -16'sh8000;
    else sat16 = v[15:0];
  endfunction

  function automatic logic signed [16:0] mod_scale(input logic [15:0] l, input logic signed [7:0] d);
    mod_scale = $signed({1'b0, l[15:8]}) * d;
  endfunction

  function automatic logic signed [16:0] lvl_mul(input logic signed [15:0] x, input logic [7:0] l);
    logic signed [24:0] p;
    p = x * $signed({1'b0, l});
    lvl_mul = p[24:8];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] st, input logic [31:0] mk);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[b*8 +: 8] = n[b*8 +: 8];
    end
    merge = r & mk;
  endfunction

  function automatic logic addr_mapped(input logic [AW-1:0] a);
    addr_mapped = (a >> 6) == '0 && a[5:2] <= `VMX_IDX_LAST;
  endfunction

  logic [15:0] tick_cnt_reg;
  logic tick;
  logic [31:0] mix_reg, ctrl_reg, route_reg;
  logic [31:0] adsr_reg [3];
  logic [31:0] ext_reg [3];
  vmx_ctrl_t ctrl;
  vmx_mix_t mix;
  vmx_route_t route;
  vmx_adsr_t adsr [3];
  vmx_envx_t ext [3];
  vmx_phase_t phase_reg [3];
  logic [31:0] acc_reg [3];
  logic [14:0] hold_cnt_reg [3];
  logic [6:0] rep_cnt_reg [3];
  logic [7:0] vgain_reg [3];
  logic [15:0] env_out [3];
  logic legato_mode;

  // Sample-rate tick; envelopes step once per tick so times scale with SAMPLE_HZ
  assign tick = tick_cnt_reg == 16'(TICK_DIV - 1);
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tick_cnt_reg <= 16'h0000;
    end else if (CE) begin
      tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
    end
  end

  // Register words viewed as field structs
  assign ctrl = vmx_ctrl_t'(ctrl_reg);
  assign mix = vmx_mix_t'(mix_reg);
  assign route = vmx_route_t'(route_reg);
  always_comb begin
    for (int e = 0; e < 3; e++) begin
      adsr[e] = vmx_adsr_t'(adsr_reg[e]);
      ext[e] = vmx_envx_t'(ext_reg[e]);
    end
  end
  assign legato_mode = ctrl.mode == VM_MONO || ctrl.mode == VM_MONO_LEGATO; // R16

  // AXI4-Lite write side: address and data taken in either order
  logic aw_ok_reg, w_ok_reg, bvalid_reg, wr_go;
  logic [AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg;
  logic [3:0] widx;
  logic wr_en;
  assign S_AXI_AWREADY = CE && !aw_ok_reg && !bvalid_reg;
  assign S_AXI_WREADY = CE && !w_ok_reg && !bvalid_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign wr_go = aw_ok_reg && w_ok_reg && !bvalid_reg;
  assign widx = awaddr_reg[5:2];
  assign wr_en = wr_go && addr_mapped(awaddr_reg) && widx != `VMX_IDX_STATUS
                 && widx < `VMX_IDX_LVL;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_ok_reg <= 1'b0;
      w_ok_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (CE) begin
      if (wr_go) begin
        aw_ok_reg <= 1'b0;
        w_ok_reg <= 1'b0;
      end else begin
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
          aw_ok_reg <= 1'b1;
          awaddr_reg <= S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
          w_ok_reg <= 1'b1;
          wdata_reg <= S_AXI_WDATA;
          wstrb_reg <= S_AXI_WSTRB;
        end
      end
    end
  end

  // Write response; read-only and unmapped words answer SLVERR
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `VMX_RESP_OKAY;
    end else if (CE) begin
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_en ? `VMX_RESP_OKAY : `VMX_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Settings registers; reset gives amp legato and mod retrigger
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mix_reg <= `VMX_MIX_RST;
      ctrl_reg <= `VMX_CTRL_RST;
      route_reg <= `VMX_ROUTE_RST;
      for (int e = 0; e < 3; e++) begin
        adsr_reg[e] <= `VMX_ADSR_RST;
        ext_reg[e] <= (e == 0) ? `VMX_EXT_AMP_RST : `VMX_EXT_MOD_RST; // R17
      end
    end else if (CE && wr_en) begin
      if (widx == `VMX_IDX_MIX) mix_reg <= merge(mix_reg, wdata_reg, wstrb_reg, '1);
      if (widx == `VMX_IDX_CTRL) ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg, `VMX_CTRL_MASK);
      if (widx == `VMX_IDX_ROUTE) route_reg <= merge(route_reg, wdata_reg, wstrb_reg, '1);
      for (int e = 0; e < 3; e++) begin
        // R22
        if (widx == `VMX_IDX_ENV + 4'(2 * e))
          adsr_reg[e] <= merge(adsr_reg[e], wdata_reg, wstrb_reg, `VMX_ADSR_MASK);
        if (widx == `VMX_IDX_ENV + 4'(2 * e + 1))
          ext_reg[e] <= merge(ext_reg[e], wdata_reg, wstrb_reg, `VMX_EXT_MASK);
      end
    end
  end

  // AXI4-Lite read side: one cycle from address to data
  logic rvalid_reg;
  logic [31:0] rdata_reg, rd_word;
  logic [1:0] rresp_reg;
  logic [3:0] ridx;
  assign S_AXI_ARREADY = CE && !rvalid_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign ridx = S_AXI_ARADDR[5:2];
  always_comb begin
    rd_word = 32'h0000_0000;
    if (ridx == `VMX_IDX_MIX) rd_word = mix_reg;
    if (ridx == `VMX_IDX_CTRL) rd_word = ctrl_reg;
    if (ridx == `VMX_IDX_ROUTE) rd_word = route_reg;
    if (ridx == `VMX_IDX_STATUS)
      rd_word = {19'h0_0000, KEY.gate, 1'b0, phase_reg[2], 1'b0, phase_reg[1], 1'b0, phase_reg[0]};
    for (int e = 0; e < 3; e++) begin
      if (ridx == `VMX_IDX_ENV + 4'(2 * e)) rd_word = adsr_reg[e];
      if (ridx == `VMX_IDX_ENV + 4'(2 * e + 1)) rd_word = ext_reg[e];
      if (ridx == `VMX_IDX_LVL + 4'(e)) rd_word = {16'h0000, env_out[e]};
    end
    if (!addr_mapped(S_AXI_ARADDR)) rd_word = 32'h0000_0000;
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `VMX_RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= addr_mapped(S_AXI_ARADDR) ? `VMX_RESP_OKAY : `VMX_RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Legato jump only with a sounding envelope and an overlapping key
  function automatic logic legato_ok(input int e);
    legato_ok = ext[e].trig == TRIG_LEGATO && legato_mode && KEY.overlap // R15 R16 R19
                && phase_reg[e] != ENV_IDLE;
  endfunction

  // Legato decision kept as a signal, so the checks below see its sampled value
  logic [2:0] legato_hit;
  always_comb begin
    for (int e = 0; e < 3; e++) begin
      legato_hit[e] = legato_ok(e); // R15
    end
  end

  function automatic logic do_loop(input int e);
    do_loop = ext[e].repeats == `VMX_REP_CONT || rep_cnt_reg[e] < ext[e].repeats; // R21
  endfunction

  // Envelope sequencers; a key strike wins over every other event
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int e = 0; e < 3; e++) begin
        phase_reg[e] <= ENV_IDLE;
        acc_reg[e] <= 32'h0000_0000;
        hold_cnt_reg[e] <= 15'h0000;
        rep_cnt_reg[e] <= 7'h00;
        vgain_reg[e] <= 8'(`VMX_GAIN_UNITY);
      end
    end else if (CE) begin
      for (int e = 0; e < 3; e++) begin
        if (KEY.strike) begin
          // R2
          vgain_reg[e] <= vel_gain(ext[e].vel, KEY.velocity); // R13
          rep_cnt_reg[e] <= 7'h00;
          hold_cnt_reg[e] <= 15'h0000;
          if (legato_ok(e)) begin
            phase_reg[e] <= ENV_SUSTAIN; // R15
            acc_reg[e] <= sus_acc(adsr[e].sustain);
          end else begin
            phase_reg[e] <= ENV_ATTACK; // R3 R14
            acc_reg[e] <= 32'h0000_0000;
          end
        end else if (!KEY.gate && phase_reg[e] != ENV_IDLE && phase_reg[e] != ENV_RELEASE) begin
          phase_reg[e] <= ENV_RELEASE; // R7 R23
        end else if (tick) begin
          case (phase_reg[e])
            ENV_ATTACK: begin
              if (adsr[e].attack == 7'h00 ||
                  acc_reg[e] >= `VMX_ACC_MAX - rate_inc(adsr[e].attack, `VMX_ATK_SHIFT)) begin
                acc_reg[e] <= `VMX_ACC_MAX; // R8
                hold_cnt_reg[e] <= 15'h0000;
                phase_reg[e] <= (ext[e].hold_duration == 7'h00) ? ENV_DECAY : ENV_HOLD; // R20
              end else begin
                acc_reg[e] <= acc_reg[e] + rate_inc(adsr[e].attack, `VMX_ATK_SHIFT); // R3 R22
              end
            end
            ENV_HOLD: begin
              // R4 R20
              if (hold_cnt_reg[e] + 15'h0001 >= ext[e].hold_duration * HOLD_STEP) begin
                phase_reg[e] <= ENV_DECAY;
              end
              hold_cnt_reg[e] <= hold_cnt_reg[e] + 15'h0001;
            end
            ENV_DECAY: begin
              // R5 R9 R10
              if (acc_reg[e] <= sus_acc(adsr[e].sustain) || acc_reg[e] - sus_acc(adsr[e].sustain)
                  <= rate_inc(adsr[e].decay, `VMX_DEC_SHIFT)) begin
                acc_reg[e] <= sus_acc(adsr[e].sustain);
                if (do_loop(e)) begin
                  phase_reg[e] <= ENV_ATTACK; // R21
                  if (ext[e].repeats != `VMX_REP_CONT) rep_cnt_reg[e] <= rep_cnt_reg[e] + 7'h01;
                end else begin
                  phase_reg[e] <= ENV_SUSTAIN;
                end
              end else begin
                acc_reg[e] <= acc_reg[e] - rate_inc(adsr[e].decay, `VMX_DEC_SHIFT);
              end
            end
            ENV_SUSTAIN: acc_reg[e] <= sus_acc(adsr[e].sustain); // R6
            ENV_RELEASE: begin
              // R11 R23
              if (acc_reg[e] <= rate_inc(adsr[e].release_s, `VMX_REL_SHIFT)) begin
                acc_reg[e] <= 32'h0000_0000;
                phase_reg[e] <= ENV_IDLE;
              end else begin
                acc_reg[e] <= acc_reg[e] - rate_inc(adsr[e].release_s, `VMX_REL_SHIFT);
              end
            end
            default: phase_reg[e] <= ENV_IDLE;
          endcase
        end
      end
    end
  end

  // Velocity-scaled envelope outputs, clipped at full scale
  always_comb begin
    for (int e = 0; e < 3; e++) begin
      env_out[e] = 16'(({8'h00, acc_reg[e][31:16]} * {16'h0000, vgain_reg[e]}) >> 7);
      if (((acc_reg[e][31:16] * 24'(vgain_reg[e])) >> 7) > 24'h00_FFFF) env_out[e] = 16'hFFFF;
    end
  end

  // Mixer pipeline: level products, master gain, then amp envelope as the VCA
  logic signed [19:0] mix_sum_reg;
  logic signed [15:0] mix_gain_reg;
  logic signed [32:0] vca;
  logic signed [28:0] gained;
  assign gained = mix_sum_reg * $signed({1'b0, ctrl.master_output_gain});
  assign vca = mix_gain_reg * $signed({1'b0, ENV_LEVEL});
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mix_sum_reg <= 20'sh0_0000;
      mix_gain_reg <= 16'sh0000;
      VOICE_OUT <= 16'sh0000;
      ENV_LEVEL <= 16'h0000;
    end else if (CE) begin
      mix_sum_reg <= 20'(lvl_mul(MIX_SRC.osc1, mix.osc1)) + 20'(lvl_mul(MIX_SRC.osc2, mix.osc2))
                   + 20'(lvl_mul(MIX_SRC.osc3, mix.osc3)) + 20'(lvl_mul(MIX_SRC.noise, mix.noise))
                   + 20'(lvl_mul(MIX_SRC.ring, ctrl.ring)); // R1
      mix_gain_reg <= sat16(32'(gained >>> 8)); // R1
      ENV_LEVEL <= env_out[0]; // R12
      VOICE_OUT <= 16'(vca >>> 16); // R12
    end
  end

  // Modulation destinations; amp to filter is an extra, switchable path
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      MOD_OUT <= '0;
    end else if (CE) begin
      MOD_OUT.shape <= 16'(mod_scale(env_out[1], route.shape)); // R18
      MOD_OUT.filter <= sat16(32'(mod_scale(env_out[1], route.filt)) // R18
                        + (ctrl.amp_to_filter ? 32'(mod_scale(env_out[0], route.amp_filt)) : 0)); // R12
      MOD_OUT.pitch <= 16'(mod_scale(env_out[2], route.pitch)); // R18
    end
  end

  default clocking vmx_cb @(posedge CLK iff CE); endclocking
  default disable iff (SYS_RST);

  full_trigger_a: assert property (KEY.strike && !legato_hit[0] |=> // R3 R14
    phase_reg[0] == ENV_ATTACK && acc_reg[0] == 32'h0000_0000)
    else $error("full trigger did not restart attack from zero");
  legato_jump_a: assert property (KEY.strike && legato_hit[0] |=> // R15
    phase_reg[0] == ENV_SUSTAIN && acc_reg[0] == sus_acc(adsr[0].sustain))
    else $error("legato note did not continue at sustain");
  mod_retrig_a: assert property (KEY.strike && ext[1].trig == TRIG_RETRIGGER |=> // R14 R16
    phase_reg[1] == ENV_ATTACK) else $error("retrigger envelope skipped attack");
  attack_instant_a: assert property (phase_reg[0] == ENV_ATTACK && tick && KEY.gate && // R8
    !KEY.strike && adsr[0].attack == 7'h00 |=> acc_reg[0] == `VMX_ACC_MAX)
    else $error("zero attack did not jump to maximum");
  hold_level_a: assert property (phase_reg[0] == ENV_HOLD |-> acc_reg[0] == `VMX_ACC_MAX) // R4
    else $error("hold phase left the maximum level");
  hold_skip_a: assert property (phase_reg[0] == ENV_ATTACK && tick && KEY.gate && !KEY.strike && // R20
    adsr[0].attack == 7'h00 && ext[0].hold_duration == 7'h00 |=> phase_reg[0] == ENV_DECAY)
    else $error("zero hold did not go straight to decay");
  decay_fall_a: assert property (phase_reg[0] == ENV_DECAY && tick && KEY.gate && // R5
    !KEY.strike |=> acc_reg[0] <= $past(acc_reg[0])) else $error("decay rose");
  sustain_zero_a: assert property (phase_reg[0] == ENV_SUSTAIN && tick && KEY.gate && // R10
    !KEY.strike && adsr[0].sustain == 7'h00 |=> acc_reg[0] == 32'h0000_0000 ##1 env_out[0] == 16'h0000)
    else $error("zero sustain left the note audible");
  release_gate_a: assert property (!KEY.gate && !KEY.strike && phase_reg[2] != ENV_IDLE && // R7 R23
    phase_reg[2] != ENV_RELEASE |=> phase_reg[2] == ENV_RELEASE)
    else $error("key release did not start release");
  release_fall_a: assert property (phase_reg[0] == ENV_RELEASE && tick && !KEY.strike |=> // R7
    acc_reg[0] < $past(acc_reg[0]) || phase_reg[0] == ENV_IDLE) else $error("release stalled");
endmodule

// File: tb/tb_vmx_voice.sv
// Self-checking bench for the voice mixer and envelope block
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_vmx_voice;
  import vmx_pkg::*;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic press = 0, lift = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rd, rdata;
  logic [1:0] resp, bresp, rresp;
  logic awrdy, wrdy, bvalid, arrdy, rvalid;
  logic signed [15:0] vout;
  logic [15:0] lvl, lvl0;
  vmx_key_t key;
  vmx_mod_t mod;
  vmx_src_t src = '0;
  int num_errors = 0, checks_done = 0;
  logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h1C};
  logic [31:0] rv [5] = '{32'h0000_00FF, 32'h0000_8000, 32'h287F_4000, 32'h0000_0000,
    32'h0100_0000};
  // Clock declared slow so a sample tick is ten cycles; hold steps stay in range
  vmx_voice #(.CLK_HZ(480000)) vmx_voice_inst (.CLK(clk), .SYS_RST(rst), .CE(1'b1),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .KEY(key), .MIX_SRC(src), .VOICE_OUT(vout), .ENV_LEVEL(lvl),
    .MOD_OUT(mod));
  vmx_keys vmx_keys_inst (.CLK(clk), .SYS_RST(rst), .press(press), .lift(lift),
    .vel(7'h50), .key(key));
  initial forever #5 clk = ~clk;
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    {awv, wv, bready} <= 3'b111;
    for (int n = 0; n < 300; n++) begin
      @(posedge clk);
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        return;
      end
    end
    num_errors++;
    close_out();
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    {arv, rready} <= 2'b11;
    for (int n = 0; n < 300; n++) begin
      @(posedge clk);
      if (arv && arrdy) arv <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        return;
      end
    end
    num_errors++;
    close_out();
  endtask
  // Poll the phase field; polling by register keeps the bus busy on purpose
  task automatic wait_ph(input int sh, input logic [2:0] ph);
    for (int n = 0; n < 3000; n++) begin
      axr(8'h0C);
      if (rd[sh +: 3] === ph) return;
    end
    num_errors++;
    close_out();
  endtask
  // One key press or release, a single cycle wide
  task automatic tap(input logic p);
    @(posedge clk);
    if (p) press <= 1'b1;
    else lift <= 1'b1;
    @(posedge clk);
    {press, lift} <= 2'b00;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      axr(ra[i]);
      `CHK("reset word", rv[i], rd)
    end
    axr(8'h40);
    `CHK("unmapped read resp", 2'b10, resp)
    axw(8'h0C, 32'h0000_0777);
    `CHK("status write resp", 2'b10, resp)
    $display("test registers done");
    // Moderate attack, fastest decay and release, mid sustain on all envelopes
    for (int i = 0; i < 3; i++) axw(8'h10 + 8'(i * 8), 32'h0040_0020);
    src.osc1 <= 16'sh4000;
    tap(1'b1);
    axr(8'h0C);
    `CHK("phases on strike", 11'h111, rd[10:0] & 11'h777)
    wait_ph(0, 3'd4);
    lvl0 = lvl;
    `CHK("voice sign", 1'b1, vout > 0)
    axw(8'h00, 32'h0000_0000);
    axr(8'h0C);
    `CHK("voice muted", 16'sh0000, vout)
    tap(1'b0);
    axr(8'h0C);
    `CHK("release phase", 3'd5, rd[2:0])
    wait_ph(0, 3'd0);
    `CHK("level idle", 16'h0000, lvl)
    $display("test envelope done");
    // Mono legato: amp envelope stays in sustain, mod envelope restarts
    axw(8'h04, 32'h0002_8000);
    tap(1'b1);
    wait_ph(0, 3'd4);
    tap(1'b1);
    axr(8'h0C);
    `CHK("legato phases", 7'h14, rd[6:0])
    axw(8'h04, 32'h0000_8000);
    tap(1'b1);
    axr(8'h0C);
    `CHK("poly retrigger", 3'd1, rd[2:0])
    repeat (3) tap(1'b0);
    wait_ph(0, 3'd0);
    $display("test legato done");
    // One hold step and sensitivity +63 on the amp envelope; mod depths on shape and pitch
    axw(8'h14, 32'h003F_0001);
    axw(8'h08, 32'h0040_0040);
    tap(1'b1);
    wait_ph(0, 3'd2);
    `CHK("hold level", 16'hFFFF, lvl)
    wait_ph(0, 3'd4);
    `CHK("velocity depth", 1'b1, lvl > lvl0)
    `CHK("mod depths", 2'b11, {mod.shape > 0, mod.pitch > 0})
    tap(1'b0);
    wait_ph(0, 3'd0);
    $display("test hold done");
    close_out();
  end
endmodule

// File: tb/vmx_keys.sv
// Keyboard note source model: presses, releases and the overlap flag
`timescale 1ns/1ns
module vmx_keys (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic press,
  input wire logic lift,
  input wire logic [6:0] vel,
  output vmx_pkg::vmx_key_t key
);
  import vmx_pkg::*;
  logic [3:0] held_reg;
  // Count held keys; overlap and velocity are only meaningful with strike
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      held_reg <= 4'h0;
      key <= '0;
    end else begin
      held_reg <= held_reg + {3'h0, press} - {3'h0, lift && held_reg != 4'h0};
      key.strike <= press;
      key.gate <= press || (held_reg > {3'h0, lift});
      key.overlap <= press ? (held_reg != 4'h0) : ~key.overlap;
      key.velocity <= press ? vel : ~key.velocity;
    end
  end
endmodule
